// File: dsi_drive_status_indicator.sv
// Drive status indicator: six status LEDs and the 7-segment state glyph
//
// How it works
// (RULE_01) Processor-run LED lit while control processors are active.
// (RULE_02) Converter-run LED lit while power stage switches, dark when all inactive.
// (RULE_03) Second converter-run LED is always dark in this variant.
// (RULE_04) Positive analog supply LED lit only while +15V rail detected.
// (RULE_05) Negative supply LED lit only while -15V rail detected.
// (RULE_06) I/O LED lit on +5V, off on supply short or undervoltage store.
// (RULE_07) Ready waiting for enable shows steady 0.
// (RULE_08) Ready waiting for enable rising edge shows steady 1.
// (RULE_09) Ready waiting for start rising edge shows steady 2.
// (RULE_10) PID disabled stop shows steady 3 or 4 by parameter group.
// (RULE_11) Enabled without start shows steady 6.
// (RULE_12) Enabled, started, reference below minimum shows steady 7.
// (RULE_13) DC bus precharge not complete shows steady 8.
// (RULE_14) Power devices active animates one segment around a figure-eight.
// (RULE_15) Emergency flashes the alarm code characters in a repeating cycle.
// (RULE_16) Self-diagnosed failure shows the hardware-failure glyph.
// (RULE_17) Firmware update flashes E, P, A on alarm, C on autoreset.
// (RULE_18) Current limiting flashes H.
// (RULE_19) Voltage limit from low DC bus flashes L.
// (RULE_20) Bus overvoltage during braking deceleration flashes U.
// (RULE_21) DC braking flashes D.
// (RULE_22) Precedence: failure, firmware, alarm, limits and braking, ready states.
// (RULE_23) One blink period for all flashing, one step period for animation.
// (RULE_24) Initialization glyph shown until the first ready state is reached.
`timescale 1ns/1ps
`include "dsi_params.svh"

module dsi_drive_status_indicator #(
	parameter int BLINK_HALF_CYC = `DSI_BLINK_HALF_CYC,
	parameter int STEP_CYC       = `DSI_STEP_CYC
) (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	// Controller status and supply monitor pins
	input  wire dsi_pkg::dsi_status_s status,
	input  wire dsi_pkg::dsi_supply_s supply_pins,
	// Indicators
	output dsi_pkg::dsi_leds_s        leds,
	output logic [6:0]                seg
);

	if (BLINK_HALF_CYC < 1 || STEP_CYC < 1) begin : g_chk
		$error("dsi: blink and step periods must be at least one cycle");
	end

	function automatic logic [6:0] seg_of_hex(input logic [3:0] v);
		case (v)
			4'h0:    seg_of_hex = 7'h3f;
			4'h1:    seg_of_hex = 7'h06;
			4'h2:    seg_of_hex = 7'h5b;
			4'h3:    seg_of_hex = 7'h4f;
			4'h4:    seg_of_hex = 7'h66;
			4'h5:    seg_of_hex = 7'h6d;
			4'h6:    seg_of_hex = 7'h7d;
			4'h7:    seg_of_hex = 7'h07;
			4'h8:    seg_of_hex = 7'h7f;
			4'h9:    seg_of_hex = 7'h6f;
			4'ha:    seg_of_hex = 7'h77;
			4'hb:    seg_of_hex = 7'h7c;
			4'hc:    seg_of_hex = 7'h39;
			4'hd:    seg_of_hex = 7'h5e;
			4'he:    seg_of_hex = 7'h79;
			default: seg_of_hex = 7'h71;
		endcase
	endfunction : seg_of_hex

	// Supply pins pass two flops; only stage two is read by logic
	dsi_pkg::dsi_supply_s sync1_r;
	dsi_pkg::dsi_supply_s sync2_r;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= supply_pins;
			sync2_r <= sync1_r;
		end
	end

	// LEDs
	dsi_pkg::dsi_leds_s leds_r;
	dsi_pkg::dsi_leds_s leds_nxt;

	always_comb begin
		leds_nxt = '0;
		leds_nxt.processor_run_led        = status.cpu_active;      // see RULE_01
		leds_nxt.converter_run_led        = status.conv_switching;  // see RULE_02
		leds_nxt.second_converter_run_led = 1'b0;                   // see RULE_03
		leds_nxt.pos_analog_supply_led    = sync2_r.pos15_ok;       // see RULE_04
		leds_nxt.neg_analog_supply_led    = sync2_r.neg15_ok;       // see RULE_05
		leds_nxt.io_supply_led            = sync2_r.p5v_ok && !sync2_r.serial_short
			&& !sync2_r.keypad_short && !status.uv_store;       // see RULE_06
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			leds_r <= '0;
		end else begin
			leds_r <= leds_nxt;
		end
	end

	assign leds = leds_r;

	// Shared blink and animation timebase
	logic [31:0] blink_cnt_r;
	logic [31:0] blink_cnt_nxt;
	logic        blink_on_r;
	logic        blink_on_nxt;
	logic [31:0] step_cnt_r;
	logic [31:0] step_cnt_nxt;
	logic [2:0]  ring_r;
	logic [2:0]  ring_nxt;
	logic        blink_fall;

	always_comb begin
		blink_cnt_nxt = blink_cnt_r + 32'h0000_0001;
		blink_on_nxt  = blink_on_r;
		blink_fall    = 1'b0;
		if (blink_cnt_r >= 32'(BLINK_HALF_CYC - 1)) begin  // see RULE_23
			blink_cnt_nxt = '0;
			blink_on_nxt  = !blink_on_r;
			blink_fall    = blink_on_r;
		end
		step_cnt_nxt = step_cnt_r + 32'h0000_0001;
		ring_nxt     = ring_r;
		if (step_cnt_r >= 32'(STEP_CYC - 1)) begin  // see RULE_23
			step_cnt_nxt = '0;
			ring_nxt     = ring_r + 3'd1;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			blink_cnt_r <= '0;
			blink_on_r  <= 1'b1;
			step_cnt_r  <= '0;
			ring_r      <= '0;
		end else begin
			blink_cnt_r <= blink_cnt_nxt;
			blink_on_r  <= blink_on_nxt;
			step_cnt_r  <= step_cnt_nxt;
			ring_r      <= ring_nxt;
		end
	end

	// Glyph selection
	logic        init_done_r;
	logic        init_done_nxt;
	logic [1:0]  alarm_pos_r;
	logic [1:0]  alarm_pos_nxt;
	logic [6:0]  seg_r;
	logic [6:0]  seg_nxt;
	logic        any_ready;
	logic [6:0]  steady;
	logic [6:0]  flash;
	logic        flashing;
	logic [3:0]  alarm_digit;
	logic [2:0]  ring_idx;

	always_comb begin
		any_ready = status.rdy_wait_enable || status.rdy_enable_edge
			|| status.rdy_start_edge || status.pid_off_grp_a
			|| status.pid_off_grp_b || status.en_no_start
			|| status.ref_below_min || status.precharge_wait
			|| status.power_active;
		// Sticky so a later drop of every ready flag shows blank, not init
		init_done_nxt = init_done_r || any_ready;  // see RULE_24

		ring_idx = 3'(`DSI_RING_ORDER >> (3 * ring_r));
		case (alarm_pos_r)
			2'd1:    alarm_digit = status.alarm_code[11:8];
			2'd2:    alarm_digit = status.alarm_code[7:4];
			2'd3:    alarm_digit = status.alarm_code[3:0];
			default: alarm_digit = `DSI_HEX_A;
		endcase

		// Alarm walk restarts from the letter each time the emergency begins
		alarm_pos_nxt = '0;
		if (status.emergency) begin
			alarm_pos_nxt = alarm_pos_r;
			if (blink_fall) begin  // see RULE_15
				alarm_pos_nxt = alarm_pos_r + 2'd1;
			end
		end

		// Ready-group glyphs, precharge first since nothing runs before it
		steady = `DSI_SEG_BLANK;
		if (status.precharge_wait) begin
			steady = seg_of_hex(4'h8);                       // see RULE_13
		end else if (status.power_active) begin
			steady = `DSI_SEG_ONE << ring_idx;               // see RULE_14
		end else if (status.ref_below_min) begin
			steady = seg_of_hex(4'h7);                       // see RULE_12
		end else if (status.en_no_start) begin
			steady = seg_of_hex(4'h6);                       // see RULE_11
		end else if (status.pid_off_grp_a) begin
			steady = seg_of_hex(4'h3);                       // see RULE_10
		end else if (status.pid_off_grp_b) begin
			steady = seg_of_hex(4'h4);                       // see RULE_10
		end else if (status.rdy_start_edge) begin
			steady = seg_of_hex(4'h2);                       // see RULE_09
		end else if (status.rdy_enable_edge) begin
			steady = seg_of_hex(4'h1);                       // see RULE_08
		end else if (status.rdy_wait_enable) begin
			steady = seg_of_hex(4'h0);                       // see RULE_07
		end

		flashing = 1'b1;
		flash    = `DSI_SEG_BLANK;
		case (status.fw_phase)
			dsi_pkg::DSI_FW_ERASE:     flash = seg_of_hex(`DSI_HEX_E);  // see RULE_17
			dsi_pkg::DSI_FW_PROGRAM:   flash = `DSI_SEG_P;              // see RULE_17
			dsi_pkg::DSI_FW_ALARM:     flash = seg_of_hex(`DSI_HEX_A);  // see RULE_17
			dsi_pkg::DSI_FW_AUTORESET: flash = seg_of_hex(`DSI_HEX_C);  // see RULE_17
			default: begin
				if (status.emergency) begin
					flash = seg_of_hex(alarm_digit);         // see RULE_15
				end else if (!init_done_r) begin
					flashing = 1'b0;
					flash    = `DSI_SEG_INIT;                // see RULE_24
				end else if (status.cur_limit) begin
					flash = `DSI_SEG_H;                      // see RULE_18
				end else if (status.volt_limit_low) begin
					flash = `DSI_SEG_L;                      // see RULE_19
				end else if (status.volt_limit_decel) begin
					flash = `DSI_SEG_U;                      // see RULE_20
				end else if (status.dc_brake) begin
					flash = `DSI_SEG_D;                      // see RULE_21
				end else begin
					flashing = 1'b0;
					flash    = steady;
				end
			end
		endcase

		// Failure outranks everything else and never blinks
		if (status.hw_fail) begin                          // see RULE_22
			seg_nxt = `DSI_SEG_HWFAIL;                       // see RULE_16
		end else if (flashing && !blink_on_r) begin        // see RULE_23
			seg_nxt = `DSI_SEG_BLANK;
		end else begin
			seg_nxt = flash;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			init_done_r <= 1'b0;
			alarm_pos_r <= '0;
			seg_r       <= `DSI_SEG_BLANK;
		end else begin
			init_done_r <= init_done_nxt;
			alarm_pos_r <= alarm_pos_nxt;
			seg_r       <= seg_nxt;
		end
	end

	assign seg = seg_r;

	// Checks
	cpu_led_follow_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_01
		status.cpu_active |=> leds.processor_run_led)
		else $error("processor LED not lit after processors active");

	conv_led_dark_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_02
		!status.conv_switching |=> !leds.converter_run_led)
		else $error("converter LED lit with power stage inactive");

	second_led_dark_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_03
		!leds.second_converter_run_led)
		else $error("second converter LED lit");

	pos_supply_led_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_04
		supply_pins.pos15_ok [*4] |-> leds.pos_analog_supply_led)
		else $error("positive supply LED dark with rail present");

	neg_supply_led_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_05
		!supply_pins.neg15_ok [*4] |-> !leds.neg_analog_supply_led)
		else $error("negative supply LED lit with rail absent");

	io_short_dark_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_06
		(supply_pins.serial_short || supply_pins.keypad_short) [*4]
		|-> !leds.io_supply_led)
		else $error("I/O LED lit during supply short");

	hw_fail_glyph_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_16
		status.hw_fail |=> seg == `DSI_SEG_HWFAIL)
		else $error("failure glyph not shown");

	init_glyph_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_24
		(!init_done_r && !any_ready && !status.hw_fail && !status.emergency
		&& status.fw_phase == dsi_pkg::DSI_FW_IDLE) |=> seg == `DSI_SEG_INIT)
		else $error("init glyph missing before first ready state");

	blink_period_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_23
		$changed(blink_on_r) |-> blink_cnt_r == '0 && $past(blink_cnt_r)
		== 32'(BLINK_HALF_CYC - 1))
		else $error("blink phase changed off period");

	ring_step_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_14
		$changed(ring_r) |-> ring_r == $past(ring_r) + 3'd1 && step_cnt_r == '0)
		else $error("animation step out of order");

endmodule : dsi_drive_status_indicator

// File: dsi_params.svh
// Constants for the drive status indicator: timing, segment patterns, animation order
`ifndef DSI_PARAMS_SVH
`define DSI_PARAMS_SVH

// Clock rate and indication timing
`define DSI_CLK_HZ          200000000
`define DSI_BLINK_HALF_MS   250
`define DSI_STEP_MS         100
`define DSI_BLINK_HALF_CYC  ((`DSI_CLK_HZ / 1000) * `DSI_BLINK_HALF_MS)
`define DSI_STEP_CYC        ((`DSI_CLK_HZ / 1000) * `DSI_STEP_MS)

// Segment patterns, bit 0 = a ... bit 6 = g, high = lit
`define DSI_SEG_BLANK       7'h00
`define DSI_SEG_INIT        7'h40
`define DSI_SEG_HWFAIL      7'h71
`define DSI_SEG_P           7'h73
`define DSI_SEG_H           7'h76
`define DSI_SEG_L           7'h38
`define DSI_SEG_U           7'h3e
`define DSI_SEG_D           7'h5e
`define DSI_SEG_ONE         7'h01

// Figure-eight walk, segment index per step, step 0 in the low bits
`define DSI_RING_ORDER      {3'd5, 3'd6, 3'd2, 3'd3, 3'd4, 3'd6, 3'd1, 3'd0}
`define DSI_RING_STEPS      8

// Alarm sequence: leading letter then three code digits
`define DSI_ALARM_POS       4
`define DSI_HEX_A           4'ha
`define DSI_HEX_C           4'hc
`define DSI_HEX_E           4'he

`endif

// File: dsi_pkg.sv
// Types shared by the drive status indicator
package dsi_pkg;

	typedef enum logic [2:0] {
		DSI_FW_IDLE,
		DSI_FW_ERASE,
		DSI_FW_PROGRAM,
		DSI_FW_ALARM,
		DSI_FW_AUTORESET
	} dsi_fw_e;

	// Drive controller status, all on the clk domain
	typedef struct packed {
		logic          cpu_active;
		logic          conv_switching;
		logic          uv_store;
		logic          hw_fail;
		dsi_fw_e       fw_phase;
		logic          emergency;
		logic [11:0]   alarm_code;
		logic          cur_limit;
		logic          volt_limit_low;
		logic          volt_limit_decel;
		logic          dc_brake;
		logic          precharge_wait;
		logic          power_active;
		logic          rdy_wait_enable;
		logic          rdy_enable_edge;
		logic          rdy_start_edge;
		logic          pid_off_grp_a;
		logic          pid_off_grp_b;
		logic          en_no_start;
		logic          ref_below_min;
	} dsi_status_s;

	// Supply monitor pins, asynchronous to clk
	typedef struct packed {
		logic pos15_ok;
		logic neg15_ok;
		logic p5v_ok;
		logic serial_short;
		logic keypad_short;
	} dsi_supply_s;

	typedef struct packed {
		logic processor_run_led;
		logic converter_run_led;
		logic second_converter_run_led;
		logic pos_analog_supply_led;
		logic neg_analog_supply_led;
		logic io_supply_led;
	} dsi_leds_s;

endpackage : dsi_pkg

// File: test_drive_status_indicator.sv
// Self-checking bench for the drive status indicator: LEDs and display glyphs
`timescale 1ns/1ps

module test_drive_status_indicator;
	localparam int BLINK = 4;
	localparam int STEP  = 3;

	logic                 clk         = 1'b0;
	logic                 sys_rst     = 1'b1;
	dsi_pkg::dsi_status_s status      = '0;
	dsi_pkg::dsi_supply_s supply_pins = '0;
	dsi_pkg::dsi_leds_s   leds;
	logic [6:0]           seg;
	int                   miscompares = 0;
	int                   check_count = 0;
	logic [15:0]          lfsr_r      = 16'h0001;
	int                   sup_age, run_n, run_len, ring_idx, apos;
	bit                   init_done, fresh;
	logic [6:0]           last_seg;
	dsi_pkg::dsi_status_s last_st;

	always #2.5 clk = ~clk;

	dsi_drive_status_indicator #(
		.BLINK_HALF_CYC(BLINK),
		.STEP_CYC      (STEP)
	) i_dut (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.status     (status),
		.supply_pins(supply_pins),
		.leds       (leds),
		.seg        (seg)
	);

	task automatic check(input logic [6:0] seen, input logic [6:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t ns: seen 0x%0h expected 0x%0h", $time, seen, exp);
		end
	endtask : check

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict

	function automatic logic [15:0] roll();
		repeat (16) lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
		return lfsr_r;
	endfunction : roll

	function automatic logic [6:0] hexg(input logic [3:0] d);
		logic [6:0] t [9];
		t = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f};
		return t[d];
	endfunction : hexg

	// Class 0 steady, 1 flashing, 2 rotating segment, 3 alarm sequence
	function automatic int classify(input dsi_pkg::dsi_status_s s, input bit done,
			output logic [6:0] g);
		g = 7'h00;
		if (s.hw_fail) g = 7'h71;
		else if (s.fw_phase != dsi_pkg::DSI_FW_IDLE) g =
			s.fw_phase == dsi_pkg::DSI_FW_ERASE ? 7'h79 : s.fw_phase == dsi_pkg::DSI_FW_PROGRAM ?
			7'h73 : s.fw_phase == dsi_pkg::DSI_FW_ALARM ? 7'h77 : 7'h39;
		else if (s.emergency) g = 7'h77;
		else if (!done) g = 7'h40;
		else if (s.cur_limit) g = 7'h76;
		else if (s.volt_limit_low) g = 7'h38;
		else if (s.volt_limit_decel) g = 7'h3e;
		else if (s.dc_brake) g = 7'h5e;
		else if (s.precharge_wait) g = 7'h7f;
		else if (s.power_active) g = 7'h01;
		else if (s.ref_below_min) g = 7'h07;
		else if (s.en_no_start) g = 7'h7d;
		else if (s.pid_off_grp_a) g = 7'h4f;
		else if (s.pid_off_grp_b) g = 7'h66;
		else if (s.rdy_start_edge) g = 7'h5b;
		else if (s.rdy_enable_edge) g = 7'h06;
		else if (s.rdy_wait_enable) g = 7'h3f;
		if (s.hw_fail) return 0;
		if (s.fw_phase != dsi_pkg::DSI_FW_IDLE) return 1;
		if (s.emergency) return 3;
		if (!done) return 0;
		if (s.cur_limit | s.volt_limit_low | s.volt_limit_decel | s.dc_brake) return 1;
		return (!s.precharge_wait && s.power_active) ? 2 : 0;
	endfunction : classify

	task automatic check_cycle();
		logic [6:0] g;
		logic [6:0] e;
		logic [6:0] aseq [4];
		int         cls;
		int         ro [8];
		bit         chg;
		ro = '{0, 1, 6, 4, 3, 2, 6, 5};
		cls = classify(status, init_done, g);
		aseq = '{7'h77, hexg(status.alarm_code[11:8]), hexg(status.alarm_code[7:4]),
			hexg(status.alarm_code[3:0])};
		sup_age++;
		check(7'(leds.processor_run_led), 7'(status.cpu_active));
		check(7'(leds.converter_run_led), 7'(status.conv_switching));
		check(7'(leds.second_converter_run_led), 7'h00);
		if (sup_age >= 3) begin
			e = 7'(supply_pins.p5v_ok & ~supply_pins.serial_short & ~supply_pins.keypad_short);
			check(7'(leds.pos_analog_supply_led), 7'(supply_pins.pos15_ok));
			check(7'(leds.neg_analog_supply_led), 7'(supply_pins.neg15_ok));
			check(7'(leds.io_supply_led), e & 7'(~status.uv_store));
		end
		chg = (status !== last_st) || fresh;
		if (chg) begin
			apos = (last_st.emergency && !fresh) ? -1 : 0;
			run_n = 0;
			ring_idx = -1;
		end
		// Classified with the old flag: the edge that first sees a ready flag still shows init
		if (!init_done && (status.rdy_wait_enable | status.rdy_enable_edge
				| status.rdy_start_edge | status.pid_off_grp_a | status.pid_off_grp_b
				| status.en_no_start | status.ref_below_min | status.precharge_wait
				| status.power_active)) begin
			init_done = 1'b1;
		end
		if (cls == 3 && apos < 0 && seg === 7'h77) apos = 0;
		if (cls == 0) check(seg, g);
		if (cls == 1) check(seg === 7'h00 ? g : seg, g);
		if (cls == 2) check(7'($countones(seg)), 7'h01);
		if (cls == 3 && seg !== 7'h00 && apos >= 0) check(seg, aseq[apos % 4]);
		if (cls == 3 && seg !== 7'h00 && apos < 0) check(7'(seg inside {aseq}), 7'h01);
		if (seg !== last_seg) begin
			if (run_n >= 2 && cls > 0 && cls < 4)
				check(7'(run_len), 7'(cls == 2 ? STEP : BLINK));
			if (cls == 3 && seg === 7'h00)
				apos = chg ? -1 : (apos >= 0 ? apos + 1 : apos);
			if (cls == 2 && ring_idx >= 0) begin
				ring_idx = (ring_idx + 1) % 8;
				check(seg, 7'(1 << ro[ring_idx]));
			end else if (cls == 2)
				for (int i = 0; i < 8; i++)
					if (ro[i] != 6 && seg === 7'(1 << ro[i])) ring_idx = i;
			run_n++;
			run_len = 0;
		end
		run_len++;
		last_seg = seg;
		last_st = status;
		fresh = 1'b0;
	endtask : check_cycle

	task automatic step(input int n);
		repeat (n) begin
			@(negedge clk);
			check_cycle();
		end
	endtask : step

	// Current limit is raised with nothing ready, so the init glyph must win
	task automatic restart();
		sys_rst = 1'b1;
		status = '0;
		status.cur_limit = 1'b1;
		supply_pins = dsi_pkg::dsi_supply_s'(5'h1c);
		repeat (3) @(negedge clk);
		check(seg, 7'h00);
		check(7'(leds), 7'h00);
		sys_rst = 1'b0;
		fresh = 1'b1;
		sup_age = 0;
		init_done = 1'b0;
		step(6);
		status.rdy_wait_enable = 1'b1;
		step(6);
	endtask : restart

	task automatic rand_vec();
		logic [15:0] a;
		logic [15:0] b;
		logic [15:0] c;
		logic [32:0] v;
		a = roll();
		b = roll();
		c = roll();
		// Thirteen single flags, twelve code bits, emergency, phase, four top flags
		v[12:0] = a[15] ? 13'(1 << (a[3:0] % 13)) : b[12:0] & c[12:0];
		v[24:13] = {4'(b[15:12] % 9), 4'(b[11:8] % 9), 4'(b[7:4] % 9)};
		v[25] = &a[14:12];
		v[28:26] = &c[15:13] ? 3'(c[1:0] + 1) : 3'h0;
		v[32:29] = {a[11:9], &c[12:10]};
		status = dsi_pkg::dsi_status_s'(v);
		supply_pins = dsi_pkg::dsi_supply_s'(c[9:5]);
		sup_age = 0;
	endtask : rand_vec

	initial begin
		restart();
		repeat (200) begin
			rand_vec();
			step(10);
		end
		restart();
		give_verdict();
	end

	// The run needs about 2,030 cycles; far beyond that something hangs
	initial begin
		#100000;
		miscompares++;
		give_verdict();
	end
endmodule : test_drive_status_indicator
